// ---- test/torque_reference_select_diag_test.sv ----
// Purpose: self-checking bench for torque select and diagnostics
// Assumes: flash counts shortened to 20 and 4
// Notes: expectations come from the mode table
`timescale 1ns/1ps
`default_nettype none
module torque_reference_select_diag_test import torque_sel_pkg::*; ;
   logic clk_sys = '0, rst = '1, torque_mode = '0, zero_torque_mode = '0, bus_activity = '0;
   logic stage_enabled = '0, disable_req = '0, fault_state = '0, op_enabled = '0;
   logic error_evt = '0, alert_evt = '0, rvalid, wr_refused, activity_dot;
   logic [15:0] error_num = '0, alert_num = '0, torque_limit_pct, rdata;
   logic signed [15:0] analog_ref = '0, target_torque_pct;
   logic [1:0] code = '0;
   logic torque_select_bit_low, torque_select_bit_high, coast_on_disable, ramp_on_disable;
   alert_cond_t alert_cond = '0;
   param_req_t req = '0;
   logic [OUT_COUNT-1:0] sig_out;
   int mismatches = 0, num_checks = 0;
   torque_select_driver drv (.*);
   torque_reference_select_diag #(.HOLD_CYCLES(20), .FLASH_DIV(4)) uut (.*);
   ////////////////////////////////////////////////////////////////
   // 50 MHz system clock
   always #10 clk_sys = ~clk_sys;
   task chk(string n, logic [15:0] s, logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask
   task summarize();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one-edge request; answer looked at just after the taking edge
   task bus(logic w, logic [15:0] a, logic [15:0] d, logic [15:0] e);
      req <= '{w, !w, a, d};
      @(posedge clk_sys);
      req <= '0;
      #1 chk(w ? "refused" : "rdata", w ? 16'(wr_refused) : rdata, e);
      if (!w) chk("rvalid", 16'(rvalid), 16'h0001);
      @(posedge clk_sys);
   endtask
   task t_regs();
      #1 chk("limit", torque_limit_pct, FULL_SCALE_RESET);
      @(posedge clk_sys);
      bus(1'b0, ADDR_FULL_SCALE, '0, FULL_SCALE_RESET);
      stage_enabled <= '1;
      bus(1'b1, ADDR_FULL_SCALE, 16'h00C8, 16'h0001);
      stage_enabled <= '0;
      bus(1'b1, ADDR_FULL_SCALE, 16'h03E9, 16'h0001);
      bus(1'b1, ADDR_FULL_SCALE, FULL_SCALE_MAX, '0);
      bus(1'b0, ADDR_FULL_SCALE, '0, FULL_SCALE_MAX);
      bus(1'b0, 16'h0300, '0, '0);
      $display("t_regs done");
   endtask
   // every code in both modes, analog at +10 V, disable held
   task t_select();
      logic [15:0] pre [4];
      pre = '{'0, 16'h0032, 16'hFF88, PRESET_MAX};
      for (int i = 1; i < 4; i++)
         bus(1'b1, ADDR_PRESET_1 + 16'(2 * i - 2), pre[i], '0);
      analog_ref <= 16'sh7FFF;
      torque_mode <= '1;
      disable_req <= '1;
      for (int m = 0; m < 2; m++) begin
         for (int c = 0; c < 4; c++) begin
            zero_torque_mode <= m[0];
            code <= c[1:0];
            pre[0] = m ? '0 : FULL_SCALE_MAX;
            repeat (3) @(posedge clk_sys);
            #1 chk("target", target_torque_pct, pre[c]);
            chk("coast", {ramp_on_disable, coast_on_disable}, 16'h0001);
            chk("limit", torque_limit_pct, FULL_SCALE_MAX);
            @(posedge clk_sys);
         end
      end
      $display("t_select done");
   endtask
   // six errors back to back, five kept
   task t_hist();
      error_evt <= '1;
      for (int i = 1; i < 7; i++) begin
         error_num <= 16'(i);
         @(posedge clk_sys);
      end
      error_evt <= '0;
      for (int k = 0; k < HIST_DEPTH; k++)
         bus(1'b0, ADDR_ERR_HIST0 + 16'(2 * k), '0, 16'(6 - k));
      alert_evt <= '1;
      alert_num <= 16'h0123;
      @(posedge clk_sys);
      alert_evt <= '0;
      bus(1'b0, ADDR_LAST_ALERT, '0, 16'h0123);
      $display("t_hist done");
   endtask
   task t_outs();
      logic [7:0] fn [5];
      fn = '{FN_NO_FAULT, FN_OP_ENABLED, FN_FAULT, FN_ALERT, FN_RESET};
      for (int i = 0; i < OUT_COUNT; i++)
         bus(1'b1, ADDR_OUT_SEL0 + 16'(2 * i), {8'h00, fn[i]}, '0);
      {torque_mode, zero_torque_mode, fault_state, op_enabled, alert_cond} <= 8'h3F;
      repeat (3) @(posedge clk_sys);
      #1 chk("outs", 16'(sig_out), 16'h000E);
      chk("ramp", {ramp_on_disable, coast_on_disable}, 16'h0002);
      @(posedge clk_sys);
      // one alert source alone must still raise the alert output
      {disable_req, fault_state, op_enabled} <= '0;
      alert_cond <= 4'b0001;
      repeat (3) @(posedge clk_sys);
      #1 chk("outs", 16'(sig_out), 16'h0009);
      @(posedge clk_sys);
      $display("t_outs done");
   endtask
   // dark when idle, lit after a frame, dark past the hold
   task t_dot();
      #1 chk("dot", 16'(activity_dot), '0);
      @(posedge clk_sys);
      bus_activity <= '1;
      @(posedge clk_sys);
      bus_activity <= '0;
      #1;
      for (int i = 0; i < 12 && activity_dot !== 1'b1; i++)
         #20;
      chk("dot", 16'(activity_dot), 16'h0001);
      repeat (30) @(posedge clk_sys);
      #1 chk("dot", 16'(activity_dot), '0);
      $display("t_dot done");
   endtask
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= '0;
      @(posedge clk_sys);
      t_regs();
      t_select();
      t_hist();
      t_outs();
      t_dot();
      summarize();
   end
   // watchdog, some fifteen times the expected run
   initial begin
      repeat (2000) @(posedge clk_sys);
      mismatches++;
      summarize();
   end
endmodule
`default_nettype wire

// ---- test/torque_sel_monitor.sv ----
// Purpose: port checks for torque select and diagnostics
// Assumes: outputs registered one edge after their inputs
// Notes: history is seen only through the read port
`timescale 1ns/1ps
`default_nettype none
module torque_sel_monitor
   import torque_sel_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic torque_mode,
   input wire logic zero_torque_mode,
   input wire logic torque_select_bit_low,
   input wire logic torque_select_bit_high,
   input wire logic signed [15:0] analog_ref,
   input wire logic stage_enabled,
   input wire logic disable_req,
   input wire logic error_evt,
   input wire logic [15:0] error_num,
   input wire param_req_t req,
   input wire logic signed [15:0] target_torque_pct,
   input wire logic [15:0] torque_limit_pct,
   input wire logic coast_on_disable,
   input wire logic ramp_on_disable,
   input wire logic [15:0] rdata,
   input wire logic wr_refused
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // shared terms; code 00 means analog or zero
   wire sel0 = !torque_select_bit_low && !torque_select_bit_high;
   wire fs_wr = req.wr && req.addr == ADDR_FULL_SCALE;
   wire torq = torque_mode || zero_torque_mode;
   sequence s_fs_ok;
      fs_wr && !stage_enabled && req.wdata <= FULL_SCALE_MAX;
   endsequence
   sequence s_err_rd;
      error_evt ##1 req.rd && req.addr == ADDR_ERR_HIST0 && !error_evt;
   endsequence
   ////////////////////////////////////////////////////////////////
   // accepted value reaches the limit output two edges on
   AST_FS_KEEP: assert property (
      s_fs_ok |=> !wr_refused ##1 torque_limit_pct == $past(req.wdata, 2))
      else $error("full-scale write lost");
   AST_FS_LOCKED: assert property (fs_wr && stage_enabled |=> wr_refused)
      else $error("full-scale write taken with stage on");
   AST_FS_RANGE: assert property (fs_wr && req.wdata > FULL_SCALE_MAX |=> wr_refused)
      else $error("full-scale above range taken");
   AST_COAST: assert property (
      disable_req && torq |=> coast_on_disable && !ramp_on_disable)
      else $error("torque mode disable not coasting");
   AST_RAMP: assert property (
      disable_req && !torq |=> ramp_on_disable && !coast_on_disable)
      else $error("other mode disable not ramping");
   AST_ZERO: assert property (zero_torque_mode && sel0 |=> target_torque_pct == '0)
      else $error("zero-torque code 00 not zero");
   AST_FULL_IN: assert property (
      torque_mode && !zero_torque_mode && sel0 && analog_ref == ADC_FULL && !req.wr
      |=> target_torque_pct == torque_limit_pct) else $error("full input not full scale");
   AST_HIST_NEW: assert property (s_err_rd |=> rdata == $past(error_num, 2))
      else $error("newest history entry wrong");
endmodule
bind torque_reference_select_diag torque_sel_monitor mon (.*);
`default_nettype wire

// ---- test/torque_select_driver.sv ----
// Purpose: controller model setting the two torque select inputs
// Assumes: bench hands it a code, applied on the next edge
// Notes: both bits switch on one edge, no skew modelled
`timescale 1ns/1ps
`default_nettype none
module torque_select_driver (
   input wire logic clk_sys,
   input wire logic [1:0] code,
   output logic torque_select_bit_low = '0,
   output logic torque_select_bit_high = '0
);
   // registered like an output card, so bits never glitch apart
   always @(posedge clk_sys) {torque_select_bit_high, torque_select_bit_low} <= code;
endmodule
`default_nettype wire

// ---- verilog/activity_flash.sv ----
// Purpose: toggles a display dot while bus activity was seen recently
// Assumes: act is a one-cycle pulse per bus frame
// Notes: dot stays dark when idle
`timescale 1ns/1ps
`default_nettype none
module activity_flash #(
   parameter int HOLD_CYCLES = 25000000,
   parameter int FLASH_CYCLES = 5000000
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic act,
   output logic dot
);
   initial begin
      if (HOLD_CYCLES < 2 || FLASH_CYCLES < 2) begin
         $error("activity_flash: counts too small");
      end
   end

   typedef struct packed {
      logic [31:0] hold;
      logic [31:0] div;
      logic dot;
   } st_t;
   st_t s_q, s_d;

   //////////////////////////////////////////////////////////////////////
   // hold window restarts on every frame; dot toggles inside the window
   always_comb begin
      s_d = s_q;
      if (act) begin
         s_d.hold = 32'(HOLD_CYCLES);
      end else if (s_q.hold != 32'h0000_0000) begin
         s_d.hold = s_q.hold - 32'h0000_0001;
      end
      if (s_q.hold == 32'h0000_0000) begin
         s_d.div = 32'h0000_0000;
         s_d.dot = 1'b0;
      end else if (s_q.div >= 32'(FLASH_CYCLES - 1)) begin
         s_d.div = 32'h0000_0000;
         s_d.dot = ~s_q.dot;
      end else begin
         s_d.div = s_q.div + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dot = s_q.dot;
endmodule
`default_nettype wire

// ---- verilog/torque_reference_select_diag.sv ----
// Purpose: target torque source selection, full-scale scaling and drive diagnostics
// Assumes: analog input already digitised, signed, ADC_FULL equals 10 V
// Notes: parameter access is a simple one-cycle read/write port from the fieldbus layer
`timescale 1ns/1ps
`default_nettype none
module torque_reference_select_diag
   import torque_sel_pkg::*;
#(
   parameter int HOLD_CYCLES = ACT_HOLD_CYCLES,
   parameter int FLASH_DIV = FLASH_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic torque_mode,
   input wire logic zero_torque_mode,
   input wire logic torque_select_bit_low,
   input wire logic torque_select_bit_high,
   input wire logic signed [15:0] analog_ref,
   input wire logic stage_enabled,
   input wire logic disable_req,
   input wire logic fault_state,
   input wire logic op_enabled,
   input wire logic error_evt,
   input wire logic [15:0] error_num,
   input wire logic alert_evt,
   input wire logic [15:0] alert_num,
   input wire alert_cond_t alert_cond,
   input wire param_req_t req,
   input wire logic bus_activity,
   output logic signed [15:0] target_torque_pct,
   output logic [15:0] torque_limit_pct,
   output logic coast_on_disable,
   output logic ramp_on_disable,
   output logic [15:0] rdata,
   output logic rvalid,
   output logic wr_refused,
   output logic [OUT_COUNT-1:0] sig_out,
   output logic activity_dot
);
   initial begin
      if (HOLD_CYCLES < 2 || FLASH_DIV < 2) begin
         $error("torque_reference_select_diag: counts too small");
      end
   end

   typedef struct packed {
      logic [15:0] full_scale;
      logic [2:0][15:0] preset;
      logic [HIST_DEPTH-1:0][15:0] hist;
      logic [15:0] last_alert;
      logic [OUT_COUNT-1:0][7:0] out_sel;
      logic signed [15:0] target;
      logic [15:0] limit;
      logic coast;
      logic ramp;
      logic [15:0] rdata;
      logic rvalid;
      logic wr_refused;
      logic [OUT_COUNT-1:0] sig_out;
   } st_t;
   st_t s_q, s_d;

   logic [1:0] sel_code;
   logic signed [32:0] scaled;
   logic signed [15:0] analog_pct;
   logic [OUT_COUNT-1:0] out_fn;
   logic any_alert;

   //////////////////////////////////////////////////////////////////////
   // analog scaling: full input gives full_scale percent, linear
   assign sel_code = {torque_select_bit_high, torque_select_bit_low};
   assign scaled = (33'(analog_ref) * $signed({17'h0_0000, s_q.full_scale}))
                   / $signed(33'(ADC_FULL));
   // truncate to 16-bit signed, no clamp; full_scale max 1000 always fits
   assign analog_pct = scaled[15:0];
   assign any_alert = alert_cond.limit_switch | alert_cond.undervoltage |
                      alert_cond.node_guard | alert_cond.op_stop;

   //////////////////////////////////////////////////////////////////////
   // output function decode per selector
   for (genvar i = 0; i < OUT_COUNT; i++) begin : g_out
      always_comb begin
         case (s_q.out_sel[i])
            FN_NO_FAULT: out_fn[i] = ~fault_state;
            FN_OP_ENABLED: out_fn[i] = op_enabled;
            FN_FAULT: out_fn[i] = fault_state;
            FN_ALERT: out_fn[i] = any_alert;
            default: out_fn[i] = 1'b0;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////
   // next-state: reference select, parameter access, diagnostics
   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      s_d.wr_refused = 1'b0;
      s_d.sig_out = out_fn;
      // percent of nominal torque throughout
      if (zero_torque_mode) begin
         if (sel_code == 2'b00) begin
            s_d.target = 16'sh0000;
         end else begin
            s_d.target = s_q.preset[sel_code - 2'b01];
         end
      end else if (torque_mode) begin
         if (sel_code == 2'b00) begin
            s_d.target = analog_pct;
         end else begin
            s_d.target = s_q.preset[sel_code - 2'b01];
         end
      end else begin
         s_d.target = 16'sh0000;
      end
      // limit used in non-torque modes
      s_d.limit = s_q.full_scale;
      // torque modes coast on disable; others may ramp
      s_d.coast = (torque_mode | zero_torque_mode) & disable_req;
      s_d.ramp = ~(torque_mode | zero_torque_mode) & disable_req;
      // error history shift, newest at entry zero
      if (error_evt) begin
         for (int k = HIST_DEPTH - 1; k > 0; k--) begin
            s_d.hist[k] = s_q.hist[k-1];
         end
         s_d.hist[0] = error_num;
      end
      // alert only stored, no state effect
      if (alert_evt) begin
         s_d.last_alert = alert_num;
      end
      // parameter writes
      if (req.wr) begin
         if (req.addr == ADDR_FULL_SCALE) begin
            if (stage_enabled || req.wdata > FULL_SCALE_MAX) begin
               s_d.wr_refused = 1'b1;
            end else begin
               s_d.full_scale = req.wdata;
            end
         end else if (req.addr >= ADDR_PRESET_1 && req.addr <= ADDR_PRESET_3 &&
                      req.addr[0] == 1'b0) begin
            if ($signed(req.wdata) > $signed(PRESET_MAX) ||
                $signed(req.wdata) < -$signed(PRESET_MAX)) begin
               s_d.wr_refused = 1'b1;
            end else begin
               s_d.preset[2'((req.addr - ADDR_PRESET_1) >> 1)] = req.wdata;
            end
         end else if (req.addr >= ADDR_OUT_SEL0 &&
                      req.addr < ADDR_OUT_SEL0 + 16'(2 * OUT_COUNT) &&
                      req.addr[0] == 1'b0) begin
            s_d.out_sel[3'((req.addr - ADDR_OUT_SEL0) >> 1)] = req.wdata[7:0];
         end else begin
            s_d.wr_refused = 1'b1;
         end
      end
      // parameter reads; unmapped reads return zero
      if (req.rd) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = 16'h0000;
         if (req.addr == ADDR_FULL_SCALE) begin
            s_d.rdata = s_q.full_scale;
         end else if (req.addr == ADDR_LAST_ALERT) begin
            s_d.rdata = s_q.last_alert;
         end else if (req.addr >= ADDR_PRESET_1 && req.addr <= ADDR_PRESET_3 &&
                      req.addr[0] == 1'b0) begin
            s_d.rdata = s_q.preset[2'((req.addr - ADDR_PRESET_1) >> 1)];
         end else if (req.addr >= ADDR_ERR_HIST0 &&
                      req.addr < ADDR_ERR_HIST0 + 16'(2 * HIST_DEPTH) &&
                      req.addr[0] == 1'b0) begin
            s_d.rdata = s_q.hist[3'((req.addr - ADDR_ERR_HIST0) >> 1)];
         end else if (req.addr >= ADDR_OUT_SEL0 &&
                      req.addr < ADDR_OUT_SEL0 + 16'(2 * OUT_COUNT) &&
                      req.addr[0] == 1'b0) begin
            s_d.rdata = {8'h00, s_q.out_sel[3'((req.addr - ADDR_OUT_SEL0) >> 1)]};
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= '0;
         s_q.full_scale <= FULL_SCALE_RESET;
         s_q.preset <= {3{PRESET_RESET}};
         s_q.out_sel <= {OUT_COUNT{FN_RESET}};
      end else begin
         s_q <= s_d;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // display dot for bus traffic
   logic dot_w;
   activity_flash #(
      .HOLD_CYCLES(HOLD_CYCLES),
      .FLASH_CYCLES(FLASH_DIV)
   ) u_flash (
      .clk_sys(clk_sys),
      .rst(rst),
      .act(bus_activity),
      .dot(dot_w)
   );

   assign target_torque_pct = s_q.target;
   assign torque_limit_pct = s_q.limit;
   assign coast_on_disable = s_q.coast;
   assign ramp_on_disable = s_q.ramp;
   assign rdata = s_q.rdata;
   assign rvalid = s_q.rvalid;
   assign wr_refused = s_q.wr_refused;
   assign sig_out = s_q.sig_out;
   assign activity_dot = dot_w; // flop inside flash module
endmodule
`default_nettype wire

// ---- verilog/torque_sel_pkg.sv ----
// Purpose: shared constants and carriers for torque reference select and diagnostics
// Assumes: one system clock, synchronous active-high reset
// Notes: percent values are unsigned, signed torque in percent of nominal
package torque_sel_pkg;
   // parameter address of the full-scale setting
   localparam logic [15:0] ADDR_FULL_SCALE = 16'h0252;
   localparam logic [15:0] ADDR_PRESET_1 = 16'h0218;
   localparam logic [15:0] ADDR_PRESET_2 = 16'h021A;
   localparam logic [15:0] ADDR_PRESET_3 = 16'h021C;
   localparam logic [15:0] ADDR_ERR_HIST0 = 16'h0400;
   localparam logic [15:0] ADDR_LAST_ALERT = 16'h005E;
   localparam logic [15:0] ADDR_OUT_SEL0 = 16'h0224;
   localparam logic [15:0] FULL_SCALE_RESET = 16'h0064;
   localparam logic [15:0] FULL_SCALE_MAX = 16'h03E8;
   localparam logic [15:0] PRESET_RESET = 16'h0000;
   localparam logic [15:0] PRESET_MAX = 16'h012C;
   localparam logic [15:0] ADC_FULL = 16'h7FFF;
   localparam int HIST_DEPTH = 5;
   localparam int OUT_COUNT = 5;
   // output function codes
   localparam logic [7:0] FN_NO_FAULT = 8'h01;
   localparam logic [7:0] FN_OP_ENABLED = 8'h02;
   localparam logic [7:0] FN_FAULT = 8'h07;
   localparam logic [7:0] FN_ALERT = 8'h0B;
   localparam logic [7:0] FN_RESET = 8'h00;
   // activity flash period, in ms at 50 MHz
   localparam int FLASH_MS = 100;
   localparam int CLK_KHZ = 50000;
   localparam int FLASH_CYCLES = FLASH_MS * CLK_KHZ;
   localparam int ACT_HOLD_MS = 500;
   localparam int ACT_HOLD_CYCLES = ACT_HOLD_MS * CLK_KHZ;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } param_req_t;

   typedef struct packed {
      logic limit_switch;
      logic undervoltage;
      logic node_guard;
      logic op_stop;
   } alert_cond_t;
endpackage
